// file: logic/rcu_top.sv
// Purpose: Reset generation and clock control with APB registers
// Assumes: Derived clocks given as pclk-based tick enables
// Notes:   Mux selects drive external clock switches
//
// Implementation choices: register access over APB and the register offsets.
`timescale 1ns/100ps

module rcu_top #(
  parameter logic [7:0] OSC_STARTUP = rcu_pkg::OSC_STARTUP_DEF
) (
  input  wire logic        pclk,            // Bus clock
  input  wire logic        presetn,         // POR/PDR reset, low
  input  wire logic        psel,            // APB select
  input  wire logic        penable,         // APB enable
  input  wire logic        pwrite,          // APB write
  input  wire logic [7:0]  paddr,           // APB byte address
  input  wire logic [31:0] pwdata,          // APB write data
  output logic      [31:0] prdata,          // APB read data
  output logic             pready,          // APB ready
  output logic             pslverr,         // APB error
  input  wire logic        ldo_ready,       // Core supply ready pin
  input  wire logic        external_reset_pin_n, // Reset pin
  input  wire logic        backup_power_on, // Backup POR pin
  input  wire logic        free_watchdog_started, // From RC40 domain
  input  wire logic        standby_exit,    // Leaving standby
  input  wire logic        window_watchdog_reset_n, // Watchdog
  input  wire logic        free_watchdog_reset_n,   // Watchdog
  input  wire logic        core_reset_request, // Core request
  input  wire logic        standby_entry,   // Entering standby
  input  wire logic        deepsleep_entry, // Entering deep-sleep
  input  wire logic        deepsleep_wake,  // Deep-sleep wake-up
  input  wire logic        no_reset_on_standby_option,   // Option
  input  wire logic        no_reset_on_deepsleep_option, // Option
  output logic             power_reset_n,   // Power reset
  output logic             system_reset_n,  // Core, peripherals
  output logic             backup_reset_n,  // Backup domain
  output logic [5:0]       osc_enable,      // Oscillator on
  output logic [5:0]       osc_stable,      // Oscillator stable
  output logic             fast_crystal_bypass, // Pin clock used
  output logic             fast_crystal_gate,   // Crystal released
  output logic             stable_irq,      // Stable interrupt
  output logic [1:0]       system_clock_select, // Active source
  output logic [1:0]       pll_source_select,   // PLL input
  output logic             ahb_tick,        // AHB clock enable
  output logic             apb1_tick,       // APB1 clock enable
  output logic             apb2_tick,       // APB2 clock enable
  output logic             timer1_tick,     // APB1 timers
  output logic             timer2_tick,     // APB2 timers
  output logic             core_tick_timer_tick, // AHB / 8
  output logic             adc_apb_tick,    // APB2 / 2..9
  output logic [1:0]       adc_clock_select,    // ADC source
  output logic [1:0]       serial0_clock_select, // Serial source
  output logic             consumer_control_clock_select, // Link
  output logic [1:0]       rtc_clock_select, // RTC source
  output logic             usb_clock_select  // USB source
);

  if (OSC_STARTUP == 8'h00) begin : g_bad_startup
    $error("OSC_STARTUP must be non-zero");
  end

  //////////////////////////////////////////////////////////////////////
  // Pin synchronisers: change counts when stages 2 and 3 agree
  logic [3:0] pins_in;
  logic [3:0] s1_reg;
  logic [3:0] s2_reg;
  logic [3:0] s3_reg;
  logic [3:0] filt_reg;
  assign pins_in = {free_watchdog_started, backup_power_on,
                    external_reset_pin_n, ldo_ready};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_reg[g]   <= rcu_pkg::SYNC_RST[g];
          s2_reg[g]   <= rcu_pkg::SYNC_RST[g];
          s3_reg[g]   <= rcu_pkg::SYNC_RST[g];
          filt_reg[g] <= rcu_pkg::SYNC_RST[g];
        end else begin
          s1_reg[g] <= pins_in[g];
          s2_reg[g] <= s1_reg[g];
          s3_reg[g] <= s2_reg[g];
          if (s2_reg[g] == s3_reg[g]) begin
            filt_reg[g] <= s3_reg[g];
          end
        end
      end
    end
  endgenerate

  wire ldo_ok   = filt_reg[0];
  wire pin_rst  = !filt_reg[1];
  wire bkp_por  = filt_reg[2];
  wire fwdg_run = filt_reg[3];

  //////////////////////////////////////////////////////////////////////
  // Resets
  logic        pwr_n_reg;
  logic [11:0] sys_cnt_reg;
  logic [11:0] sys_cnt_next;
  logic        sys_src;

  // outputs reach only core and peripherals
  assign sys_src = !pwr_n_reg || pin_rst
    || !window_watchdog_reset_n || !free_watchdog_reset_n
    || core_reset_request
    || (standby_entry && !no_reset_on_standby_option)
    || (deepsleep_entry && !no_reset_on_deepsleep_option);
  assign sys_cnt_next = sys_src ? rcu_pkg::SYS_RST_CYC :
                        (sys_cnt_reg != 12'h000) ?
                        sys_cnt_reg - 12'h001 : 12'h000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_n_reg   <= 1'b0;
      sys_cnt_reg <= rcu_pkg::SYS_RST_CYC;
    end else begin
      pwr_n_reg   <= ldo_ok && !standby_exit;
      sys_cnt_reg <= sys_cnt_next;
    end
  end

  assign power_reset_n  = pwr_n_reg;
  assign system_reset_n = (sys_cnt_reg == 12'h000);

  //////////////////////////////////////////////////////////////////////
  // Control registers
  logic [5:0] en_reg;
  logic [5:0] en_next;
  logic [5:0] ie_reg;
  logic       byp_reg;
  logic [1:0] scs_reg;
  logic [1:0] scss_reg;
  logic [1:0] scss_next;
  logic [3:0] ahb_psc_reg;
  logic [2:0] apb1_psc_reg;
  logic [2:0] apb2_psc_reg;
  logic [1:0] pll_src_reg;
  logic [1:0] ser_sel_reg;
  logic       cec_sel_reg;
  logic [1:0] adc_sel_reg;
  logic [2:0] adc_div_reg;
  logic       usb_sel_reg;
  logic [1:0] rtc_sel_reg;
  logic       bkp_bit_reg;
  logic [5:0] stb;
  logic [5:0] eff_en;
  logic [5:0] used;

  wire acc  = psel && penable;
  wire wr   = acc && pwrite;
  wire a_c0 = (paddr == rcu_pkg::CTL0_OFS);
  wire a_f0 = (paddr == rcu_pkg::CFG0_OFS);
  wire a_f2 = (paddr == rcu_pkg::CFG2_OFS);
  wire a_c1 = (paddr == rcu_pkg::CTL1_OFS);
  wire a_in = (paddr == rcu_pkg::INT_OFS);
  wire a_bd = (paddr == rcu_pkg::BDCTL_OFS);
  wire a_rs = (paddr == rcu_pkg::RSTSCK_OFS);
  wire hit  = a_c0 || a_f0 || a_f2 || a_c1 || a_in || a_bd || a_rs;

  // Sources that feed the system clock or the PLL
  assign used[rcu_pkg::OSC_RC8] = (scss_reg == rcu_pkg::SRC_RC8)
    || (en_reg[rcu_pkg::OSC_PLL] && pll_src_reg == 2'b00);
  assign used[rcu_pkg::OSC_FX] = (scss_reg == rcu_pkg::SRC_FX)
    || (en_reg[rcu_pkg::OSC_PLL] && pll_src_reg == 2'b01);
  assign used[rcu_pkg::OSC_PLL] = (scss_reg == rcu_pkg::SRC_PLL);
  assign used[rcu_pkg::OSC_RC28] = 1'b0;
  assign used[rcu_pkg::OSC_RC48] =
    en_reg[rcu_pkg::OSC_PLL] && pll_src_reg == 2'b10;
  assign used[rcu_pkg::OSC_RC40] = 1'b0;

  wire [5:0] wr_en = {pwdata[0], pwdata[rcu_pkg::CTL1_RC48], pwdata[0],
                      pwdata[rcu_pkg::CTL0_PLL_EN],
                      pwdata[rcu_pkg::CTL0_FX_EN], pwdata[0]};
  wire [5:0] wr_sel = {a_rs, a_c1, a_c1, a_c0, a_c0, a_c0};
  wire [5:0] ds_clr = deepsleep_entry ? 6'h06 : 6'h00;

  // Enable writes cannot stop a source in use
  assign en_next = ((wr ? ((en_reg & ~wr_sel) | (wr_en & wr_sel))
                        : en_reg) | (en_reg & used)) & ~ds_clr;

  assign eff_en = en_reg | {fwdg_run, 5'h00};

  // Switch only once the requested source is stable; deep-sleep wake forces RC8 at once
  wire tgt_ok = (scs_reg == rcu_pkg::SRC_RC8) ? stb[rcu_pkg::OSC_RC8] :
                (scs_reg == rcu_pkg::SRC_FX)  ? stb[rcu_pkg::OSC_FX]  :
                (scs_reg == rcu_pkg::SRC_PLL) ? stb[rcu_pkg::OSC_PLL] :
                1'b0;
  assign scss_next = deepsleep_wake ? rcu_pkg::SRC_RC8 :
                     tgt_ok ? scs_reg : scss_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg       <= rcu_pkg::OSC_EN_RST;
      ie_reg       <= 6'h00;
      byp_reg      <= 1'b0;
      scs_reg      <= rcu_pkg::SRC_RC8;
      scss_reg     <= rcu_pkg::SRC_RC8;
      ahb_psc_reg  <= 4'h0;
      apb1_psc_reg <= 3'h0;
      apb2_psc_reg <= 3'h0;
      pll_src_reg  <= 2'h0;
      ser_sel_reg  <= 2'h0;
      cec_sel_reg  <= 1'b0;
      adc_sel_reg  <= 2'h0;
      adc_div_reg  <= 3'h0;
      usb_sel_reg  <= 1'b0;
      rtc_sel_reg  <= 2'h0;
      bkp_bit_reg  <= 1'b0;
    end else begin
      en_reg   <= en_next;
      scss_reg <= scss_next;
      if (deepsleep_wake) begin
        scs_reg <= rcu_pkg::SRC_RC8;
      end else if (wr && a_f0) begin
        scs_reg <= pwdata[1:0];
      end
      if (wr && a_c0 && !en_reg[rcu_pkg::OSC_FX]) begin
        byp_reg <= pwdata[rcu_pkg::CTL0_FX_BYP];
      end
      if (wr && a_f0) begin
        ahb_psc_reg  <= pwdata[7:4];
        apb1_psc_reg <= pwdata[10:8];
        apb2_psc_reg <= pwdata[13:11];
        pll_src_reg  <= pwdata[17:16];
      end
      if (wr && a_f2) begin
        ser_sel_reg <= pwdata[1:0];
        cec_sel_reg <= pwdata[2];
        adc_sel_reg <= pwdata[4:3];
        adc_div_reg <= pwdata[10:8];
      end
      if (wr && a_c1) begin
        usb_sel_reg <= pwdata[rcu_pkg::CTL1_USBSEL];
      end
      if (wr && a_in) begin
        ie_reg <= pwdata[5:0];
      end
      if (wr && a_bd) begin
        rtc_sel_reg <= pwdata[9:8];
        bkp_bit_reg <= pwdata[rcu_pkg::BD_RESET];
      end
    end
  end

  assign backup_reset_n = !(bkp_bit_reg || bkp_por);

  //////////////////////////////////////////////////////////////////////
  // Start-up counters per oscillator
  generate
    for (g = 0; g < rcu_pkg::OSC_N; g++) begin : g_osc
      logic [7:0] cnt_reg;
      logic       stb_reg;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_reg <= 8'h00;
          stb_reg <= 1'b0;
        end else if (!eff_en[g]) begin
          cnt_reg <= 8'h00;
          stb_reg <= 1'b0;
        end else if (cnt_reg == OSC_STARTUP) begin
          stb_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
      assign stb[g] = stb_reg;
    end
  endgenerate

  assign osc_enable          = eff_en;
  assign osc_stable          = stb;
  assign fast_crystal_gate   = stb[rcu_pkg::OSC_FX];
  assign fast_crystal_bypass = byp_reg && en_reg[rcu_pkg::OSC_FX];
  assign stable_irq = |(stb & ie_reg);
  assign system_clock_select = scss_reg;
  assign pll_source_select   = pll_src_reg;
  assign adc_clock_select    = adc_sel_reg;
  assign serial0_clock_select = ser_sel_reg;
  assign consumer_control_clock_select = cec_sel_reg;
  assign rtc_clock_select    = rtc_sel_reg;
  assign usb_clock_select    = usb_sel_reg;

  //////////////////////////////////////////////////////////////////////
  // Prescalers as tick enables from one free-running counter
  function automatic logic [3:0] apb_shift(input logic [2:0] code);
    apb_shift = code[2] ? {2'b00, code[1:0]} + 4'h1 : 4'h0;
  endfunction

  function automatic logic [15:0] low_mask(input logic [3:0] sh);
    low_mask = ~(16'hFFFF << sh);
  endfunction

  logic [15:0] div_reg;
  logic [3:0]  adc_cnt_reg;
  wire [3:0] ahb_sh = ahb_psc_reg[3] ? {1'b0, ahb_psc_reg[2:0]} + 4'h1
                                     : 4'h0;
  wire [3:0] p1_sh  = apb_shift(apb1_psc_reg);
  wire [3:0] p2_sh  = apb_shift(apb2_psc_reg);
  wire [3:0] t1_sh  = (p1_sh == 4'h0) ? 4'h0 : p1_sh - 4'h1;
  wire [3:0] t2_sh  = (p2_sh == 4'h0) ? 4'h0 : p2_sh - 4'h1;
  wire [15:0] m_ahb = low_mask(ahb_sh);
  wire [15:0] m_p1  = low_mask(ahb_sh + p1_sh);
  wire [15:0] m_p2  = low_mask(ahb_sh + p2_sh);
  wire [15:0] m_t1  = low_mask(ahb_sh + t1_sh);
  wire [15:0] m_t2  = low_mask(ahb_sh + t2_sh);
  wire [15:0] m_st  = low_mask(ahb_sh + 4'(rcu_pkg::CORE_TICK_TIMER_SHIFT));

  assign ahb_tick  = ((div_reg & m_ahb) == m_ahb);
  assign apb1_tick = ((div_reg & m_p1) == m_p1);
  assign apb2_tick = ((div_reg & m_p2) == m_p2);
  assign timer1_tick = ((div_reg & m_t1) == m_t1);
  assign timer2_tick = ((div_reg & m_t2) == m_t2);
  assign core_tick_timer_tick = ((div_reg & m_st) == m_st);
  // ADC divider: code 0..7 gives 2..9 APB2 ticks
  wire adc_wrap = (adc_cnt_reg == {1'b0, adc_div_reg} + 4'h1);
  assign adc_apb_tick = apb2_tick && adc_wrap;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg      <= 16'h0000;
      adc_cnt_reg  <= 4'h0;
    end else begin
      div_reg <= div_reg + 16'h0001;
      if (apb2_tick) begin
        adc_cnt_reg <= adc_wrap ? 4'h0 : adc_cnt_reg + 4'h1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // APB read path, zero wait states
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata =
    !(psel && !pwrite) ? 32'h0000_0000 :
    a_c0 ? {6'h00, stb[2], en_reg[2], 5'h00, byp_reg, stb[1],
            en_reg[1], 14'h0000, stb[0], en_reg[0]} :
    a_f0 ? {14'h0000, pll_src_reg, 2'h0, apb2_psc_reg, apb1_psc_reg,
            ahb_psc_reg, scss_reg, scs_reg} :
    a_f2 ? {21'h000000, adc_div_reg, 3'h0, adc_sel_reg, cec_sel_reg,
            ser_sel_reg} :
    a_c1 ? {13'h0000, usb_sel_reg, stb[4], en_reg[4], 14'h0000,
            stb[3], en_reg[3]} :
    a_in ? {18'h00000, stb, 2'h0, ie_reg} :
    a_bd ? {15'h0000, bkp_bit_reg, 6'h00, rtc_sel_reg, 8'h00} :
    a_rs ? {30'h00000000, stb[5], en_reg[5]} : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pwr_rst_ldo: assert property (
    !ldo_ok |=> !power_reset_n) else $error("power reset not held");
  a_sys_from_pwr: assert property (
    !power_reset_n |=> !system_reset_n ##1 !system_reset_n)
    else $error("power reset did not reach system reset");
  a_sys_stretch: assert property (
    sys_src |=> sys_cnt_reg == rcu_pkg::SYS_RST_CYC)
    else $error("system reset stretch not loaded");
  a_sys_count: assert property (
    !sys_src && sys_cnt_reg > 12'h001 |=> !system_reset_n)
    else $error("system reset released early");
  a_bkp_rst_bit: assert property (
    bkp_bit_reg || bkp_por |-> !backup_reset_n)
    else $error("backup reset missing");
  a_switch_hold: assert property (
    !tgt_ok && !deepsleep_wake |=> $stable(scss_reg))
    else $error("clock switched to unstable source");
  a_keep_used: assert property (
    used[rcu_pkg::OSC_FX] && !deepsleep_entry |=> en_reg[rcu_pkg::OSC_FX])
    else $error("source in use was stopped");
  a_wake_rc8: assert property (
    deepsleep_wake |=> system_clock_select == rcu_pkg::SRC_RC8)
    else $error("wake did not select rc8");
  a_stable_drop: assert property (
    !eff_en[rcu_pkg::OSC_PLL] |=> !stb[rcu_pkg::OSC_PLL])
    else $error("stable flag kept after disable");
  a_stable_rise: assert property (
    $rose(stb[rcu_pkg::OSC_FX]) |-> $past(eff_en[rcu_pkg::OSC_FX], 2))
    else $error("stable without enable");
  a_tick_eight: assert property (
    core_tick_timer_tick |-> ahb_tick ##1 !core_tick_timer_tick [*7])
    else $error("tick timer not ahb by eight");

endmodule

// file: logic/rcu_pkg.sv
// Purpose: Constants for the reset and clock unit
// Assumes: 32-bit APB, pclk at 100 MHz
// Notes:   Offsets are byte addresses
package rcu_pkg;
  // Register byte offsets
  localparam logic [7:0] CTL0_OFS   = 8'h00;
  localparam logic [7:0] CFG0_OFS   = 8'h04;
  localparam logic [7:0] CFG2_OFS   = 8'h08;
  localparam logic [7:0] CTL1_OFS   = 8'h0C;
  localparam logic [7:0] INT_OFS    = 8'h10;
  localparam logic [7:0] BDCTL_OFS  = 8'h14;
  localparam logic [7:0] RSTSCK_OFS = 8'h18;
  // Oscillator index in enable and stable vectors
  localparam int OSC_RC8  = 0;
  localparam int OSC_FX   = 1;
  localparam int OSC_PLL  = 2;
  localparam int OSC_RC28 = 3;
  localparam int OSC_RC48 = 4;
  localparam int OSC_RC40 = 5;
  localparam int OSC_N    = 6;
  // Field positions
  localparam int CTL0_FX_EN  = 16;
  localparam int CTL0_FX_BYP = 18;
  localparam int CTL0_PLL_EN = 24;
  localparam int CTL1_RC48   = 16;
  localparam int CTL1_USBSEL = 18;
  localparam int BD_RESET    = 16;
  // Reset values
  localparam logic [5:0] OSC_EN_RST = 6'h01;
  localparam logic [3:0] SYNC_RST   = 4'h2;
  // System clock sources
  typedef enum logic [1:0] {
    SRC_RC8 = 2'b00,
    SRC_FX  = 2'b01,
    SRC_PLL = 2'b10
  } rcu_src_t;
  // Timing
  localparam int CLK_MHZ    = 100;
  localparam int SYS_RST_US = 20;
  localparam int SYS_RST_CYC_I = SYS_RST_US * CLK_MHZ;
  localparam logic [11:0] SYS_RST_CYC = 12'(SYS_RST_CYC_I);
  localparam int CORE_TICK_TIMER_SHIFT = 3;
  localparam logic [7:0] OSC_STARTUP_DEF = 8'h20;
endpackage

// file: sim/rcu_partner.sv
// Purpose: Regulator and reset consumer facing the unit
// Assumes: One pclk domain
// Notes:   Measures each system reset pulse in cycles
`timescale 1ns/100ps
module rcu_partner (
  input  wire logic pclk,           // Bus clock
  input  wire logic system_reset_n, // Reset to core
  output logic      ldo_ready,      // Core supply ready
  output int        low_len,        // Last pulse length
  output int        pulses          // Pulses seen
);
  int cur;
  int up;
  initial begin
    ldo_ready = 1'b0;
    low_len   = 0;
    pulses    = 0;
    cur       = 0;
    up        = 0;
  end
  // Supply settles some cycles after power-up
  always @(posedge pclk) begin
    if (up < 20) up <= up + 1;
    ldo_ready <= (up >= 20);
    if (system_reset_n !== 1'b1) cur <= cur + 1;
    else if (cur != 0) begin
      low_len <= cur;
      pulses  <= pulses + 1;
      cur     <= 0;
    end
  end
endmodule

// file: sim/reset_and_clock_unit_tb.sv
// Purpose: Self-checking bench for the reset and clock unit
// Assumes: Zero-wait APB, short oscillator start-up
// Notes:   Model keeps every written register word
`timescale 1ns/100ps
module reset_and_clock_unit_tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, v;
  logic        pready, pslverr, er, ldo_ready, fws = 0, wake = 0, bpo = 0;
  logic [6:0]  flt = 0;
  logic [1:0]  opt = 0, scs, adc_s, ser_s, rtc_s;
  logic        por_n, sys_n, bkp_n, byp, gate, cec_s, usb_s;
  logic        t_ahb, t_ap1, t_tm1, t_core, t_ap2, t_adc, irq;
  int          e, f;
  logic [5:0]  oen, ost;
  int          errors = 0, comparisons = 0, cyc = 0, lo, np, a, b, c, d, n, k;
  int          mreg[8];

  rcu_top #(.OSC_STARTUP(8'h04)) i_rcu_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ldo_ready(ldo_ready),
    .external_reset_pin_n(~flt[0]), .backup_power_on(bpo),
    .free_watchdog_started(fws), .standby_exit(flt[5]),
    .window_watchdog_reset_n(~flt[1]), .free_watchdog_reset_n(~flt[2]),
    .core_reset_request(flt[6]), .standby_entry(flt[3]),
    .deepsleep_entry(flt[4]), .deepsleep_wake(wake),
    .no_reset_on_standby_option(opt[0]),
    .no_reset_on_deepsleep_option(opt[1]), .power_reset_n(por_n),
    .system_reset_n(sys_n), .backup_reset_n(bkp_n), .osc_enable(oen),
    .osc_stable(ost), .fast_crystal_bypass(byp), .fast_crystal_gate(gate),
    .stable_irq(irq), .system_clock_select(scs), .pll_source_select(),
    .ahb_tick(t_ahb), .apb1_tick(t_ap1), .apb2_tick(t_ap2),
    .timer1_tick(t_tm1), .timer2_tick(), .core_tick_timer_tick(t_core),
    .adc_apb_tick(t_adc),
    .adc_clock_select(adc_s), .serial0_clock_select(ser_s),
    .consumer_control_clock_select(cec_s), .rtc_clock_select(rtc_s),
    .usb_clock_select(usb_s));
  rcu_partner i_rcu_partner (.pclk(pclk), .system_reset_n(sys_n),
    .ldo_ready(ldo_ready), .low_len(lo), .pulses(np));

  initial begin
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("Counts: %0d compares, %0d mismatches", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(string s, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(logic w, logic [7:0] ad, logic [31:0] dt);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= dt;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    if (w) mreg[ad[4:2]] = dt;
  endtask
  task rdc(string s, logic [7:0] ad, logic [31:0] m);
    apb(0, ad, 0);
    chk(s, mreg[ad[4:2]] & m, rd & m);
  endtask
  task hold(int cnt);
    repeat (cnt) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      $display("[ERR] run length expected 0 seen 1");
      finish_test;
    end
  end
  initial begin
    void'($urandom(59410));
    mreg = '{default: 0};
    hold(6);
    presetn <= 1;
    for (n = 0; n < 3000 && sys_n !== 1'b1; n++) @(posedge pclk);
    hold(2);
    chk("por stretch", 1, lo >= 2000);
    chk("src", 0, scs);
    mreg[0] = 1;
    rdc("ctl0", 8'h00, 32'h1);
    apb(1, 8'h10, 32'h1);
    hold(1);
    chk("irq", 1, irq);
    $display("Test power-up done");
    apb(1, 8'h04, 32'h400);
    apb(1, 8'h08, 32'h700);
    a = 0; b = 0; c = 0; d = 0; e = 0; f = 0;
    repeat (800) begin
      @(posedge pclk);
      a += int'(t_ahb); b += int'(t_core);
      c += int'(t_ap1); d += int'(t_tm1);
      e += int'(t_adc); f += int'(t_ap2);
    end
    chk("adc div", 1, e >= f / 9 - 1 && e <= f / 9 + 1);
    chk("tick8", 1, b >= a / 8 - 1 && b <= a / 8 + 1);
    chk("apb1", 1, c >= a / 2 - 1 && c <= a / 2 + 1);
    chk("timer", 1, d >= a - 1 && d <= a + 1);
    $display("Test prescalers done");
    apb(1, 8'h00, 32'h10001);
    for (n = 0; n < 100 && ost[1] !== 1'b1; n++) @(posedge pclk);
    chk("xtal gate", 1, gate);
    apb(1, 8'h04, 32'h401);
    for (n = 0; n < 10 && scs !== 2'b01; n++) @(posedge pclk);
    chk("switch", 1, scs);
    apb(1, 8'h00, 32'h1);
    hold(1);
    chk("keep xtal", 1, oen[1]);
    wake <= 1;
    @(posedge pclk);
    wake <= 0;
    hold(2);
    chk("wake src", 0, scs);
    apb(1, 8'h00, 32'h1);
    hold(2);
    chk("xtal off", 0, {oen[1], ost[1]});
    apb(1, 8'h00, 32'h50001);
    hold(1);
    chk("bypass", 1, byp);
    $display("Test clock switch done");
    for (k = 0; k < 3; k++) begin
      v = $urandom;
      apb(1, 8'h08, v & 32'h71F);
      apb(1, 8'h14, v & 32'h300);
      apb(1, 8'h0C, v & 32'h40000);
      hold(1);
      chk("adc", v[4:3], adc_s);
      chk("ser", v[1:0], ser_s);
      chk("cec", v[2], cec_s);
      chk("rtc", v[9:8], rtc_s);
      chk("usb", v[18], usb_s);
      rdc("cfg2", 8'h08, 32'h71F);
    end
    apb(0, 8'h40, 0);
    chk("unmapped err", 1, er);
    chk("unmapped data", 0, rd);
    $display("Test selects done");
    fws <= 1;
    apb(1, 8'h18, 0);
    hold(5);
    chk("rc40 forced", 1, oen[5]);
    apb(1, 8'h14, 32'h10000);
    hold(1);
    chk("bkp bit", 0, bkp_n);
    apb(1, 8'h14, 0);
    bpo <= 1;
    hold(6);
    chk("bkp por", 0, bkp_n);
    bpo <= 0;
    hold(6);
    chk("sys kept", 1, sys_n);
    $display("Test backup done");
    for (int j = 0; j < 9; j++) begin
      k = (j < 7) ? j : j - 4;
      c = np;
      opt <= (j < 7) ? 2'b00 : 2'b11;
      flt[k] <= 1;
      hold(6);
      if (k == 5) chk("power", 0, por_n);
      flt <= 0;
      for (n = 0; n < 3000 && (sys_n !== 1'b1 || n < 8); n++) @(posedge pclk);
      hold(2);
      chk("pulses", c + (j < 7), np);
      if (j < 7) chk("stretch", 1, lo >= 2000);
    end
    $display("Test reset sources done");
    finish_test;
  end
endmodule
